// ### src/chan_input_bank.sv
// Channel input-select register bank with register-map checksum
// Overview of operation
// - Select code 00 connects the channel's own positive and negative pins.
// - Select code 01 disconnects the pins and shorts the converter inputs.
// - Select code 10 applies the positive and 11 the negative test signal.
// - Channel 0 register sits at 09h, resets to zero, select in bits 1:0.
// - Channel 1 register sits at 0Eh and resets to zero.
// - Channel 2 register sits at 13h and resets to zero.
// - Channel 3 register sits at 18h and resets to zero.
// - The checksum register sits at 3Eh and reads zero after reset.
// - The checksum register is a read-only 16-bit register-map CRC value.
module chan_input_bank
  import chmux_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic crc_load,
  input wire logic [15:0] crc_value,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_addr_err,
  output logic rsvd_wr_err,
  output logic [3:0] ch_route_pins,
  output logic [3:0] ch_short,
  output logic [3:0] ch_test_pos,
  output logic [3:0] ch_test_neg
);
`include "chmux_cfg.svh"

  // ===========================================
  // Declarations
  logic [15:0] chan_r [4];
  logic [15:0] crc_r;
  logic [3:0] chan_hit;
  logic crc_hit;
  logic [15:0] rd_mux;
  chan_sel_if sel_bus ();

  // ===========================================
  // Address decode
  addr_map u_addr_map (
    .addr(reg_addr),
    .chan_hit(chan_hit),
    .crc_hit(crc_hit)
  );

  // ===========================================
  // Channel registers
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_chan
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          chan_r[i] <= `CHAN_SEL_RESET;
        end else if (reg_wr && chan_hit[i]) begin
          chan_r[i] <= reg_wdata & `CHAN_KEEP_MASK;
        end
      end
      assign sel_bus.sel[i] = input_sel_t'(chan_r[i][`SEL_MSB:`SEL_LSB]);
    end
  endgenerate

  // ===========================================
  // Checksum register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      crc_r <= `CHECKSUM_RESET;
    end else if (crc_load) begin
      crc_r <= crc_value;
    end
  end

  // ===========================================
  // Read path
  always_comb begin
    rd_mux = 16'h0000;
    for (int k = 0; k < 4; k++) begin
      if (chan_hit[k]) begin
        rd_mux = chan_r[k] & ~`CHAN_RSVD_RO_MASK;
      end
    end
    if (crc_hit) begin
      rd_mux = crc_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // ===========================================
  // Access errors
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_addr_err <= 1'b0;
      rsvd_wr_err <= 1'b0;
    end else begin
      reg_addr_err <= (reg_rd || reg_wr) && !(|chan_hit) && !crc_hit;
      rsvd_wr_err <= reg_wr && (|chan_hit) &&
                     (|(reg_wdata & `CHAN_RSVD_WR_MASK));
    end
  end

  // ===========================================
  // Analog switch controls
  ch_route u_ch_route (
    .sel_bus(sel_bus)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ch_route_pins <= 4'hF;
      ch_short <= 4'h0;
      ch_test_pos <= 4'h0;
      ch_test_neg <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        ch_route_pins[k] <= sel_bus.route[k].pins;
        ch_short[k] <= sel_bus.route[k].shorted;
        ch_test_pos[k] <= sel_bus.route[k].test_pos;
        ch_test_neg[k] <= sel_bus.route[k].test_neg;
      end
    end
  end

endmodule // chan_input_bank

// ### src/chmux_cfg.svh
// Register offsets, field positions and reset values of the channel bank
`ifndef CHMUX_CFG_SVH
`define CHMUX_CFG_SVH

`define ADDR_W 6
`define DATA_W 16
`define CHAN_N 4

`define CHAN0_SEL_ADDR 6'h09
`define CHAN1_SEL_ADDR 6'h0E
`define CHAN2_SEL_ADDR 6'h13
`define CHAN3_SEL_ADDR 6'h18
`define CHECKSUM_ADDR 6'h3E

`define CHAN_SEL_RESET 16'h0000
`define CHECKSUM_RESET 16'h0000

`define SEL_LSB 0
`define SEL_MSB 1
`define CHAN_KEEP_MASK 16'hFFC7
`define CHAN_RSVD_WR_MASK 16'hFFC4
`define CHAN_RSVD_RO_MASK 16'h0038

`endif

// ### src/chmux_pkg.sv
// Types shared by the channel input-select bank
package chmux_pkg;

  typedef enum logic [1:0] {
    SEL_PINS = 2'h0,
    SEL_SHORT = 2'h1,
    SEL_TEST_POS = 2'h2,
    SEL_TEST_NEG = 2'h3
  } input_sel_t;

  typedef struct packed {
    logic pins;
    logic shorted;
    logic test_pos;
    logic test_neg;
  } route_t;

endpackage

// ### src/chan_sel_if.sv
// Carries channel selects to the route decoder and its decoded controls back
interface chan_sel_if;
  import chmux_pkg::*;
  input_sel_t [3:0] sel;
  route_t [3:0] route;
  modport cfg (output sel, input route);
  modport dec (input sel, output route);
endinterface

// ### src/addr_map.sv
// Address decoder of the channel bank
module addr_map
  import chmux_pkg::*;
(
  input wire logic [5:0] addr,
  output logic [3:0] chan_hit,
  output logic crc_hit
);
`include "chmux_cfg.svh"

  // ===========================================
  // Decode
  localparam logic [5:0] CHAN_ADDR [4] = '{
    `CHAN0_SEL_ADDR, `CHAN1_SEL_ADDR, `CHAN2_SEL_ADDR, `CHAN3_SEL_ADDR
  };

  function automatic logic hit_of(input logic [5:0] a, input logic [5:0] t);
    hit_of = (a == t);
  endfunction

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_hit
      assign chan_hit[i] = hit_of(addr, CHAN_ADDR[i]);
    end
  endgenerate

  assign crc_hit = hit_of(addr, `CHECKSUM_ADDR);

endmodule // addr_map

// ### src/ch_route.sv
// Decodes each channel's input select into analog switch controls
module ch_route
  import chmux_pkg::*;
(
  chan_sel_if.dec sel_bus
);

  // ===========================================
  // Per-channel decode
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_ch
      always_comb begin
        sel_bus.route[i] = '0;
        case (sel_bus.sel[i])
          SEL_PINS: sel_bus.route[i].pins = 1'b1;
          SEL_SHORT: sel_bus.route[i].shorted = 1'b1;
          SEL_TEST_POS: sel_bus.route[i].test_pos = 1'b1;
          SEL_TEST_NEG: sel_bus.route[i].test_neg = 1'b1;
          default: sel_bus.route[i] = '0;
        endcase
      end
    end
  endgenerate

endmodule // ch_route

// ### test/chmux_assertions.sv
// Port checks of the channel input-select bank
module chmux_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic crc_load,
  input wire logic [15:0] crc_value,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_addr_err,
  input wire logic rsvd_wr_err,
  input wire logic [3:0] ch_route_pins,
  input wire logic [3:0] ch_short,
  input wire logic [3:0] ch_test_pos,
  input wire logic [3:0] ch_test_neg
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic chan = reg_addr inside {6'h09, 6'h0E, 6'h13, 6'h18};
  wire logic w0 = reg_wr && reg_addr == 6'h09;
  sequence crc_rd;
    crc_load ##1 !crc_load ##1 (!crc_load && reg_rd && reg_addr == 6'h3E);
  endsequence
  sequence short0_wr;
    w0 && reg_wdata[1:0] == 2'h1 ##1 !w0;
  endsequence
  rd_ack_a:
    assert property (reg_rd |=> reg_rvalid) else $error("no read ack");
  no_stray_a:
    assert property (!reg_rd |=> !reg_rvalid) else $error("stray ack");
  rsvd_zero_a:
    assert property (reg_rvalid |-> reg_rdata[5:3] == 3'h0) else $error("rsvd");
  route_one_a:
    assert property ($countones({ch_route_pins, ch_short, ch_test_pos,
      ch_test_neg}) == 4 && (ch_route_pins | ch_short | ch_test_pos |
      ch_test_neg) == 4'hF) else $error("route not one-hot");
  crc_read_a:
    assert property (crc_rd |=> reg_rdata == $past(crc_value, 3))
      else $error("crc read");
  unmap_err_a:
    assert property (reg_rd && !chan && reg_addr != 6'h3E |=> reg_addr_err
      && reg_rdata == 16'h0000) else $error("unmapped read");
  rsvd_wr_a:
    assert property (reg_wr && chan && |(reg_wdata & 16'hFFC4) |=>
      rsvd_wr_err) else $error("rsvd write");
  short_route_a:
    assert property (short0_wr |-> ##1 ch_short[0]) else $error("short");
endmodule // chmux_assertions
bind chan_input_bank chmux_assertions chk_u (.*);

// ### test/host_model.sv
// Host model driving the register strobe port
module host_model (
  input wire logic clk,
  output logic [5:0] reg_addr = 6'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [15:0] reg_wdata = 16'h0000,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~v;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = (reg_rvalid === 1'b1) ? reg_rdata : 16'hDEAD;
  endtask
endmodule // host_model

// ### test/tb.sv
// Self-checking bench of the channel input-select bank
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic crc_load = 1'b0;
  logic [15:0] crc_value = 16'h0000;
  logic [5:0] reg_addr;
  logic reg_wr, reg_rd, reg_rvalid, reg_addr_err, rsvd_wr_err;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [3:0] ch_route_pins, ch_short, ch_test_pos, ch_test_neg;
  logic [5:0] ca [4] = '{6'h09, 6'h0E, 6'h13, 6'h18};
  int err_count = 0;
  int n_tests = 0;
  always #12.5 ref_clk = ~ref_clk;
  host_model host_u (.clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  chan_input_bank dut_u (.*);
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 4; i++) begin
      host_u.rd(ca[i], d);
      check("chan rst", d, 16'h0000);
    end
    host_u.rd(6'h3E, d);
    check("crc rst", d, 16'h0000);
    check("pins rst", {12'h000, ch_route_pins}, 16'h000F);
  endtask
  task automatic t_rerst;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    check("pins rerst", {12'h000, ch_route_pins}, 16'h000F);
    for (int i = 0; i < 4; i++) begin
      host_u.rd(ca[i], d);
      check("chan rerst", d, 16'h0000);
    end
    host_u.rd(6'h3E, d);
    check("crc rerst", d, 16'h0000);
  endtask
  task automatic t_select;
    for (int ch = 0; ch < 4; ch++) begin
      for (int c = 0; c < 4; c++) begin
        host_u.wr(ca[ch], 16'(c));
        @(posedge ref_clk);
        #1;
        check("route", {12'h000, ch_test_neg[ch], ch_test_pos[ch],
          ch_short[ch], ch_route_pins[ch]}, 16'h0001 << c);
        host_u.rd(ca[ch], d);
        check("sel", d, 16'(c));
      end
    end
  endtask
  task automatic t_rsvd;
    host_u.wr(ca[1], 16'hFFFF);
    #1;
    check("rsvd err", {15'h0000, rsvd_wr_err}, 16'h0001);
    host_u.rd(ca[1], d);
    check("rsvd rd", d, 16'hFFC7);
    host_u.wr(ca[1], 16'h0003);
    #1;
    check("rsvd clean", {15'h0000, rsvd_wr_err}, 16'h0000);
  endtask
  task automatic t_crc;
    host_u.wr(6'h3E, 16'h1234);
    host_u.rd(6'h3E, d);
    check("crc wr", d, 16'h0000);
    @(posedge ref_clk);
    crc_load <= 1'b1;
    crc_value <= 16'hA5C3;
    @(posedge ref_clk);
    crc_load <= 1'b0;
    host_u.rd(6'h3E, d);
    check("crc ld", d, 16'hA5C3);
  endtask
  task automatic t_unmap;
    host_u.wr(6'h0A, 16'h0002);
    #1;
    check("map err", {15'h0000, reg_addr_err}, 16'h0001);
    host_u.rd(6'h0A, d);
    check("map rd", d, 16'h0000);
    host_u.rd(ca[0], d);
    check("ch0 kept", d, 16'h0003);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_select;
    t_rsvd;
    t_crc;
    t_unmap;
    t_rerst;
    complete_run;
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    err_count++;
    complete_run;
  end
endmodule // tb
